// ==== design/fbp_gate.sv ====
// Flash array with erase blocks, paired protection units and access checking
//
// What this block does
// - 96 KB, erase touches one 1-KB block
// - Erased block reads all ones
// - One protection setting per 2-KB pair
// - Unit is open, read-only or execute-only
// - Read-only refuses erase and program
// - Execute-only: no modify, fetch reads only
// - Read data returned next cycle, no waits
`timescale 1ns/1ps
`include "fbp_defs.svh"

module fbp_gate (
	input  wire logic                           clock,
	input  wire logic                           rstn,
	input  wire logic                           clockEnable,
	input  wire logic                           reqValid,
	input  wire fbp_pkg::fbp_src_t              reqSrc,
	input  wire fbp_pkg::fbp_op_t               reqOp,
	input  wire logic [`FBP_ADDR_BITS-1:0]      reqAddr,
	input  wire logic [`FBP_WORD_BITS-1:0]      reqWdata,
	input  wire logic                           protWrite,
	input  wire logic [`FBP_UNIT_BITS-1:0]      protUnit,
	input  wire fbp_pkg::fbp_prot_t             protValue,
	input  wire logic                           violationClear,
	output logic                                rspValid,
	output logic [`FBP_WORD_BITS-1:0]           rspData,
	output logic                                rspDenied,
	output logic                                violation,
	output logic [`FBP_ADDR_BITS-1:0]           violationAddr,
	output fbp_pkg::fbp_src_t                   violationSrc
);
	import fbp_pkg::*;

	// ============================================================
	// Storage
	logic [`FBP_WORD_BITS-1:0] mem [`FBP_WORDS];
	fbp_prot_t                 prot [`FBP_UNITS];
	logic                      allow;
	logic [`FBP_UNIT_BITS-1:0] reqUnit;
	logic [`FBP_BLK_BITS-1:0]  reqBlock;
	fbp_prot_t                 unitProt;
	logic [`FBP_BLK_BITS-1:0]  pairBlock;

	function automatic logic [`FBP_UNIT_BITS-1:0] unitOf(input logic [`FBP_ADDR_BITS-1:0] a);
		return a[`FBP_ADDR_BITS-1:`FBP_UNIT_LSB];
	endfunction

	assign reqUnit  = unitOf(reqAddr);
	assign reqBlock = reqAddr[`FBP_ADDR_BITS-1:`FBP_BLK_LSB];
	assign unitProt = prot[reqUnit];
	assign pairBlock = reqBlock ^ 7'h01;

	fbp_access_check uCheck (
		.prot  (unitProt),
		.src   (reqSrc),
		.op    (reqOp),
		.allow (allow)
	);

	// ============================================================
	// Protection settings
	// per-unit marking
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `FBP_UNITS; i++) begin
				prot[i] <= fbp_prot_t'(`FBP_PROT_RESET);
			end
		end else if (clockEnable && protWrite && protUnit < `FBP_UNIT_BITS'(`FBP_UNITS)) begin
			prot[protUnit] <= protValue;
		end
	end

	// ============================================================
	// Array writes; no reset so it maps to memory
	always_ff @(posedge clock) begin
		if (clockEnable && reqValid && allow) begin
			if (reqOp == FBP_OP_PROGRAM) begin
				// Flash programming only clears bits
				mem[reqAddr] <= mem[reqAddr] & reqWdata;
			end else if (reqOp == FBP_OP_ERASE) begin
				for (int w = 0; w < `FBP_BLOCK_WORDS; w++) begin
					mem[{reqBlock, 8'(w)}] <= `FBP_ERASED_WORD;
				end
			end
		end
	end

	// ============================================================
	// Response
	// one-cycle read answer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rspValid  <= 1'b0;
			rspDenied <= 1'b0;
			rspData   <= '0;
		end else if (clockEnable) begin
			rspValid  <= reqValid;
			rspDenied <= reqValid && !allow;
			// Refused and non-read answers carry zeros so nothing leaks
			rspData   <= (reqValid && reqOp == FBP_OP_READ && allow) ? mem[reqAddr] : '0;
		end
	end

	// ============================================================
	// Violation flag, set wins over clear
	// sticky violation record
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			violation     <= 1'b0;
			violationAddr <= '0;
			violationSrc  <= FBP_SRC_FETCH;
		end else if (clockEnable) begin
			if (reqValid && !allow) begin
				violation     <= 1'b1;
				violationAddr <= reqAddr;
				violationSrc  <= reqSrc;
			end else if (violationClear) begin
				// Only reached with no refusal this cycle, so a fresh one is never lost
				violation <= 1'b0;
			end
		end
	end

	// ============================================================
	// Checks
	property pDeniedFlags;
		@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && !allow) |=> (violation && rspDenied && rspValid);
	endproperty
	deny_sets_flag_a: assert property (pDeniedFlags) else $error("denied request not flagged");

	read_one_cycle_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_READ) |=> rspValid)
		else $error("read answer late");

	ro_no_modify_a: assert property (@(posedge clock) disable iff (!rstn)
		(reqValid && reqOp != FBP_OP_READ && prot[reqUnit] == FBP_READ_ONLY) |-> !allow)
		else $error("modify allowed on read-only unit");

	xo_data_read_a: assert property (@(posedge clock) disable iff (!rstn)
		(reqValid && prot[reqUnit] == FBP_EXEC_ONLY && reqSrc != FBP_SRC_FETCH) |-> !allow)
		else $error("non-fetch access allowed on execute-only unit");

	xo_fetch_ok_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_READ && reqSrc == FBP_SRC_FETCH)
		|=> !rspDenied)
		else $error("fetch read refused");

	erase_ones_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_ERASE && allow) |=>
		(mem[{$past(reqBlock), 8'h00}] == `FBP_ERASED_WORD))
		else $error("erased block not all ones");

	denied_clean_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && !allow) |=> (rspData == '0))
		else $error("denied read leaked data");

	sticky_flag_a: assert property (@(posedge clock) disable iff (!rstn)
		(violation && !violationClear) |=> violation)
		else $error("violation flag dropped");

	// ============================================================
	// Checks on stored contents; === because unerased words are unknown
	erase_scope_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_ERASE && allow) |=>
		(mem[{$past(pairBlock), 8'h00}] === $past(mem[{pairBlock, 8'h00}])))
		else $error("erase reached the paired block");

	deny_no_write_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_PROGRAM && !allow) |=>
		(mem[$past(reqAddr)] === $past(mem[reqAddr])))
		else $error("refused program changed the word");

	read_data_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_READ && allow) |=>
		(rspData === $past(mem[reqAddr])))
		else $error("read data does not match the array");

	// ============================================================
	// Checks on permissions and the violation record
	open_allows_a: assert property (@(posedge clock) disable iff (!rstn)
		(reqValid && unitProt == FBP_OPEN) |-> allow)
		else $error("request refused on open unit");

	xo_no_modify_a: assert property (@(posedge clock) disable iff (!rstn)
		(reqValid && reqOp != FBP_OP_READ && unitProt == FBP_EXEC_ONLY) |-> !allow)
		else $error("modify allowed on execute-only unit");

	ro_read_ok_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && reqOp == FBP_OP_READ && unitProt == FBP_READ_ONLY)
		|=> !rspDenied)
		else $error("read refused on read-only unit");

	prot_update_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && protWrite && protUnit < `FBP_UNIT_BITS'(`FBP_UNITS)) |=>
		(prot[$past(protUnit)] == $past(protValue)))
		else $error("protection setting not stored");

	capture_addr_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && reqValid && !allow) |=>
		(violationAddr == $past(reqAddr) && violationSrc == $past(reqSrc)))
		else $error("violation record wrong");

	clear_drops_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && violationClear && !(reqValid && !allow)) |=> !violation)
		else $error("violation flag not cleared");

	rsp_single_a: assert property (@(posedge clock) disable iff (!rstn)
		(clockEnable && !reqValid) |=> (!rspValid && !rspDenied))
		else $error("answer without a request");

	cover_denied_c:  cover property (@(posedge clock) reqValid && !allow);
	cover_erase_c:   cover property (@(posedge clock) reqValid && reqOp == FBP_OP_ERASE && allow);
	cover_xofetch_c: cover property (@(posedge clock)
		reqValid && prot[reqUnit] == FBP_EXEC_ONLY && reqSrc == FBP_SRC_FETCH);
	cover_clrset_c:  cover property (@(posedge clock)
		violationClear && reqValid && !allow);
	cover_frozen_c:  cover property (@(posedge clock) !clockEnable && reqValid);
endmodule

// ==== design/fbp_defs.svh ====
// Constants for the flash block protection gatekeeper
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH

// ============================================================
// Array geometry
`define FBP_WORD_BITS      32
`define FBP_ADDR_BITS      15
`define FBP_WORDS          24576
`define FBP_BLOCK_KB       1
`define FBP_ERASE_BLOCKS   96
`define FBP_BLK_BITS       7
`define FBP_BLK_LSB        8
`define FBP_UNIT_LSB       9
`define FBP_UNITS          48
`define FBP_UNIT_BITS      6
`define FBP_BLOCK_WORDS    256
`define FBP_ERASED_WORD    32'hffffffff

// ============================================================
// Reset values
`define FBP_PROT_RESET     2'h0

`endif

// ==== design/fbp_pkg.sv ====
// Types for the flash block protection gatekeeper
`include "fbp_defs.svh"

package fbp_pkg;
	typedef enum logic [1:0] {
		FBP_OPEN,
		FBP_READ_ONLY,
		FBP_EXEC_ONLY
	} fbp_prot_t;

	typedef enum logic [1:0] {
		FBP_SRC_FETCH,
		FBP_SRC_DATA,
		FBP_SRC_DEBUG
	} fbp_src_t;

	typedef enum logic [1:0] {
		FBP_OP_READ,
		FBP_OP_PROGRAM,
		FBP_OP_ERASE
	} fbp_op_t;
endpackage

// ==== design/fbp_access_check.sv ====
// Permission decision for one request against one protection setting
`timescale 1ns/1ps

module fbp_access_check (
	input  wire fbp_pkg::fbp_prot_t prot,
	input  wire fbp_pkg::fbp_src_t  src,
	input  wire fbp_pkg::fbp_op_t   op,
	output logic                    allow
);
	import fbp_pkg::*;

	always_comb begin
		allow = 1'b1;
		if (op != FBP_OP_READ && prot != FBP_OPEN) begin
			allow = 1'b0;
		end
		if (op == FBP_OP_READ && prot == FBP_EXEC_ONLY && src != FBP_SRC_FETCH) begin
			allow = 1'b0;
		end
	end
endmodule

// ==== verification/fbp_requester.sv ====
// Requester model for fetch, data and debug paths
`timescale 1ns/1ps
`include "fbp_defs.svh"
module fbp_requester (
	input  wire logic                  clock,
	output logic                       reqValid,
	output fbp_pkg::fbp_src_t          reqSrc,
	output fbp_pkg::fbp_op_t           reqOp,
	output logic [`FBP_ADDR_BITS-1:0]  reqAddr,
	output logic [`FBP_WORD_BITS-1:0]  reqWdata
);
	import fbp_pkg::*;
	initial begin
		reqValid = 1'b0;
		reqSrc = FBP_SRC_FETCH;
		reqOp = FBP_OP_READ;
		reqAddr = 15'h0000;
		reqWdata = 32'h0;
	end
	// Address and data lines inverted when idle so stale values never look valid; source and op are left as issued
	task automatic issue(fbp_src_t s, fbp_op_t o, logic [14:0] a, logic [31:0] d);
		@(posedge clock);
		#1;
		reqValid = 1'b1;
		reqSrc = s;
		reqOp = o;
		reqAddr = a;
		reqWdata = d;
		@(posedge clock);
		#1;
		reqValid = 1'b0;
		reqAddr = ~a;
		reqWdata = ~d;
	endtask
endmodule

// ==== verification/flash_block_protection_tb_top.sv ====
// Self-checking bench for the flash gatekeeper
`timescale 1ns/1ps
`include "fbp_defs.svh"
module flash_block_protection_tb_top;
	import fbp_pkg::*;
	logic clock = 1'b0, rstn = 1'b0, protWrite = 1'b0, violationClear = 1'b0;
	logic clockEnable = 1'b1, frz = 1'b0;
	logic reqValid, rspValid, rspDenied, violation, ev;
	fbp_src_t reqSrc, violationSrc;
	fbp_op_t reqOp;
	fbp_prot_t protValue = FBP_OPEN;
	fbp_prot_t pr [48];
	logic [5:0] protUnit = 6'h00;
	logic [14:0] reqAddr, violationAddr;
	logic [31:0] reqWdata, rspData, r, rng = 32'h0000004c;
	logic [31:0] sh [int];
	int err_total, samples_checked;
	always #2.5 clock = ~clock;
	fbp_requester req (.clock(clock), .reqValid(reqValid), .reqSrc(reqSrc), .reqOp(reqOp),
		.reqAddr(reqAddr), .reqWdata(reqWdata));
	fbp_gate uut (.clock(clock), .rstn(rstn), .clockEnable(clockEnable), .reqValid(reqValid),
		.reqSrc(reqSrc), .reqOp(reqOp), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.protWrite(protWrite), .protUnit(protUnit), .protValue(protValue),
		.violationClear(violationClear), .rspValid(rspValid), .rspData(rspData),
		.rspDenied(rspDenied), .violation(violation), .violationAddr(violationAddr),
		.violationSrc(violationSrc));
	// ============================================================
	// Helpers
	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic ok(fbp_prot_t p, fbp_src_t s, fbp_op_t o);
		if (o != FBP_OP_READ) return p == FBP_OPEN;
		return p != FBP_EXEC_ONLY || s == FBP_SRC_FETCH;
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic prot(logic [5:0] u, fbp_prot_t v);
		@(posedge clock);
		#1;
		protWrite = 1'b1;
		clockEnable = 1'b1;
		protUnit = u;
		protValue = v;
		@(posedge clock);
		#1;
		protWrite = 1'b0;
		if (u < 6'd48) pr[u] = v;
	endtask
	task automatic xfer(fbp_src_t s, fbp_op_t o, logic [14:0] a, logic [31:0] d, logic c);
		logic g, t;
		logic [31:0] e;
		// A frozen request is never taken: no answer, no write, flag kept
		t = !frz;
		g = ok(pr[a[14:9]], s, o);
		e = (t && g && o == FBP_OP_READ) ? sh[a] : 32'h0;
		@(posedge clock);
		#1;
		chk("idle rspValid", 1'b0, rspValid);
		clockEnable = t;
		violationClear = c;
		req.issue(s, o, a, d);
		violationClear = 1'b0;
		ev = t ? (!g || (ev && !c)) : ev;
		chk("rspValid", t, rspValid);
		chk("rspDenied", t && !g, rspDenied);
		chk("rspData", e, rspData);
		chk("violation", ev, violation);
		if (t && !g) chk("violationAddr", a, violationAddr);
		if (t && !g) chk("violationSrc", s, violationSrc);
		if (t && g && o == FBP_OP_ERASE)
			for (int i = 0; i < 256; i++) sh[{a[14:8], 8'h00} + i] = '1;
		if (t && g && o == FBP_OP_PROGRAM) sh[a] &= d;
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ============================================================
	// Tests
	initial begin
		#100000;
		err_total++;
		results;
	end
	initial begin
		foreach (pr[i]) pr[i] = FBP_OPEN;
		ev = 1'b0;
		repeat (10) @(posedge clock);
		#1 rstn = 1'b1;
		for (int b = 0; b < 96; b++) xfer(FBP_SRC_DATA, FBP_OP_ERASE, 15'(b << 8), 0, 0);
		$display("erase sweep done");
		prot(6'd3, FBP_EXEC_ONLY);
		for (int s = 0; s < 3; s++) xfer(fbp_src_t'(s), FBP_OP_READ, 15'h07ff, 0, 0);
		xfer(FBP_SRC_DATA, FBP_OP_PROGRAM, 15'h0600, 32'h0, 1);
		frz = 1'b1;
		xfer(FBP_SRC_DATA, FBP_OP_PROGRAM, 15'h0010, 32'h0, 0);
		frz = 1'b0;
		xfer(FBP_SRC_FETCH, FBP_OP_READ, 15'h0010, 0, 0);
		$display("exec-only corner done");
		for (int i = 0; i < 400; i++) begin
			r = nxt();
			if (r[3:0] == 4'h0) prot(r[9:4], fbp_prot_t'(r[11:10] % 3));
			frz = (r[19:17] == 3'h0);
			xfer(fbp_src_t'(r[13:12] % 3), fbp_op_t'(r[15:14] % 3), 15'(nxt() % 24576),
				nxt(), r[16]);
		end
		$display("random traffic done");
		results;
	end
endmodule
